// ---- src/ulm_line_modem_ctrl.sv ----
// Purpose: Line/modem control and status for one serial channel, APB slave
// Assumes: Shifters, baud generator and IR codec sit outside this block
// Notes: Reads act at the setup edge, writes at the access edge
// What this block does
// - Break bit forces transmit line low
// - Divisor-access bit redirects data-register accesses
// - DTR control bit drives DTR pin low
// - RTS control bit drives RTS pin low
// - Pair select picks RTS/CTS or DTR/DSR
// - Second user-output bit, loopback source only
// - Loopback bit enters internal loopback mode
// - Xon-any lets any character resume transmit
// - Infrared bit loads from strap after reset
// - Infrared mode routes through codec, idle low
// - Prescaler bit divides baud clock by four
// - Line-status interrupt on any errored character
// - Line-status read clears bits one to four
// - Data-ready while any character is held
// - Overrun on full FIFO, FIFO untouched
// - Parity/framing bits follow head character
// - Break sets flag, one break character stored
// - Holding-empty sets on drain, clears on write
// - Transmitter-empty when holding and shifter empty
// - FIFO error bit while errored entries remain
// - CTS and DSR changes set delta flags
// - Ring delta only on RI pin rising
// - Carrier-detect change sets delta flag
// - Upper modem bits: inverted pins or loopback
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps

module ulm_line_modem_ctrl (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset straps
  input wire logic soft_reset,
  input wire logic infrared_strap,
  // Receive shifter side
  input wire ulm_pkg::ulm_rx_char_s rx_char,
  input wire logic xoff_seen,
  input wire logic xon_seen,
  output logic rx_line,
  // Transmit shifter side
  input wire logic tx_shift_bit,
  input wire logic tx_shift_busy,
  input wire logic tx_take,
  output logic [7:0] tx_data,
  output logic tx_valid,
  // Infrared codec
  input wire logic ir_tx_encoded,
  input wire logic ir_rx_decoded,
  output logic ir_decoder_in,
  // Serial and modem pins
  input wire logic serial_in,
  output logic serial_out,
  input wire ulm_pkg::ulm_modem_in_s modem_in,
  output logic dtr_n,
  output logic rts_n,
  // Baud generator feed
  output logic [15:0] divisor,
  output logic prescale_tick,
  // Interrupt requests
  output logic ls_irq,
  output logic thr_irq,
  output logic ms_irq
);

  ulm_pkg::ulm_state_s s_q;
  ulm_pkg::ulm_state_s s_d;

  // Address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a);
    if (a == ulm_pkg::OFF_DATA) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_IER) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_LCR) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_MCR) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_LSR) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_MSR) begin
      addr_mapped = 1'b1;
    end else if (a == ulm_pkg::OFF_FEAT) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction : addr_mapped

  // Any error tag on a stored entry
  function automatic logic has_err(input ulm_pkg::ulm_entry_s e);
    has_err = e.pe | e.fe | e.brk;
  endfunction : has_err

  logic rd_ev;
  logic wr_ev;
  logic dlab;
  logic loop;
  logic ir_on;
  logic [4:0] cap;
  logic rx_push;
  logic rx_pop;
  logic rx_drop;
  logic tx_push;
  logic tx_pop;
  logic flow_stop;
  logic rx_high;
  logic line_out;
  logic idle_lvl;
  logic thre;
  logic temt;
  logic [3:0] eff;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [7:0] rd_val;
  ulm_pkg::ulm_entry_s new_e;
  ulm_pkg::ulm_entry_s head;

  // Zero wait states; only unmapped addresses raise an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);

  // Status words built from current state
  always_comb begin
    dlab = s_q.line_control[ulm_pkg::LCR_DLAB];
    loop = s_q.modem_control[ulm_pkg::MCR_LOOP];
    ir_on = s_q.modem_control[ulm_pkg::MCR_IR];
    thre = (s_q.tx_cnt == 5'h00);
    temt = thre & ~tx_shift_busy;
    if (loop) begin
      eff = {s_q.modem_control[ulm_pkg::MCR_OUT2], s_q.modem_control[ulm_pkg::MCR_PAIR],
             s_q.modem_control[ulm_pkg::MCR_DTR], s_q.modem_control[ulm_pkg::MCR_RTS]};
    end else begin
      eff = ~{modem_in.cd_n, modem_in.ri_n, modem_in.dsr_n, modem_in.cts_n};
    end
    lsr_val = {(s_q.rx_errs != 5'h00), temt, thre, s_q.bi, s_q.fe, s_q.pe,
               s_q.ovr, (s_q.rx_cnt != 5'h00)};
    msr_val = {eff, s_q.delta};
  end

  // Read mux; the divisor shares the data and enable offsets
  always_comb begin
    rd_val = 8'h00;
    if (paddr == ulm_pkg::OFF_DATA) begin
      rd_val = dlab ? s_q.div[7:0] : s_q.rx_mem[s_q.rx_rd].data;
    end else if (paddr == ulm_pkg::OFF_IER) begin
      rd_val = dlab ? s_q.div[15:8] : s_q.interrupt_enable;
    end else if (paddr == ulm_pkg::OFF_LCR) begin
      rd_val = s_q.line_control;
    end else if (paddr == ulm_pkg::OFF_MCR) begin
      rd_val = s_q.modem_control;
    end else if (paddr == ulm_pkg::OFF_LSR) begin
      rd_val = lsr_val;
    end else if (paddr == ulm_pkg::OFF_MSR) begin
      rd_val = msr_val;
    end else if (paddr == ulm_pkg::OFF_FEAT) begin
      rd_val = s_q.feat;
    end
  end

  // FIFO handshakes and flow control terms
  always_comb begin
    rd_ev = psel & ~penable & ~pwrite;
    wr_ev = psel & penable & pwrite;
    cap = s_q.feat[ulm_pkg::FEAT_FIFO_EN] ? ulm_pkg::FIFO_CAP : 5'h01;
    new_e = '{brk: rx_char.brk, fe: rx_char.fe, pe: rx_char.pe,
              data: rx_char.data};
    head = s_q.rx_mem[s_q.rx_rd];
    // one break character per break condition
    rx_drop = rx_char.brk & s_q.brk_seen;
    // full FIFO refuses the new character
    rx_push = rx_char.valid & ~rx_drop & (s_q.rx_cnt < cap);
    // data offset reads the holding side only without divisor access
    rx_pop = rd_ev & (paddr == ulm_pkg::OFF_DATA) & ~dlab &
             (s_q.rx_cnt != 5'h00);
    tx_push = wr_ev & (paddr == ulm_pkg::OFF_DATA) & ~dlab &
              (s_q.tx_cnt < cap);
    // stop input of the selected pair, auto mode only
    flow_stop = s_q.feat[ulm_pkg::FEAT_AUTOFLOW] &
                (s_q.modem_control[ulm_pkg::MCR_PAIR] ? modem_in.dsr_n
                                            : modem_in.cts_n);
    rx_high = s_q.feat[ulm_pkg::FEAT_AUTOFLOW] &
              (s_q.rx_cnt >= ulm_pkg::FLOW_LVL);
    tx_valid = ~thre & ~s_q.halted & ~flow_stop;
    tx_pop = tx_take & tx_valid;
  end

  // Line routing: break, infrared and loopback
  always_comb begin
    idle_lvl = ~ir_on;
    // break forces space on the line
    if (s_q.line_control[ulm_pkg::LCR_BREAK]) begin
      line_out = 1'b0;
    end else begin
      line_out = ir_on ? ir_tx_encoded : tx_shift_bit;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.pre_tick = 1'b0;

    // strap sampled once after reset release or soft reset
    if (~s_q.strap_done | soft_reset) begin
      s_d.modem_control[ulm_pkg::MCR_IR] = infrared_strap;
      s_d.strap_done = 1'b1;
    end

    // Register writes take effect at the access edge
    if (wr_ev) begin
      if (paddr == ulm_pkg::OFF_DATA) begin
        // divisor low byte under divisor access
        if (dlab) begin
          s_d.div[7:0] = pwdata[7:0];
        end else if (tx_push) begin
          s_d.tx_mem[s_q.tx_wr] = pwdata[7:0];
        end
      end else if (paddr == ulm_pkg::OFF_IER) begin
        if (dlab) begin
          s_d.div[15:8] = pwdata[7:0];
        end else begin
          s_d.interrupt_enable = pwdata[7:0];
        end
      end else if (paddr == ulm_pkg::OFF_LCR) begin
        s_d.line_control = pwdata[7:0];
      end else if (paddr == ulm_pkg::OFF_MCR) begin
        s_d.modem_control = pwdata[7:0];
      end else if (paddr == ulm_pkg::OFF_FEAT) begin
        s_d.feat = pwdata[7:0];
      end
    end

    // Read data is captured at the setup edge with its side effects
    if (rd_ev) begin
      s_d.prdata = {24'h000000, rd_val};
    end
    // line-status read clears bits one to four
    if (rd_ev & (paddr == ulm_pkg::OFF_LSR)) begin
      s_d.ovr = 1'b0;
      s_d.pe = 1'b0;
      s_d.fe = 1'b0;
      s_d.bi = 1'b0;
    end
    if (rd_ev & (paddr == ulm_pkg::OFF_MSR)) begin
      s_d.delta = 4'h0;
    end

    // Receive FIFO; sets below win over the read clears above
    if (rx_push) begin
      s_d.rx_mem[s_q.rx_wr] = new_e;
      s_d.rx_wr = s_q.rx_wr + 4'h1;
    end
    if (rx_pop) begin
      s_d.rx_rd = s_q.rx_rd + 4'h1;
    end
    s_d.rx_cnt = s_q.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    // count of errored entries still stored
    s_d.rx_errs = s_q.rx_errs + {4'h0, rx_push & has_err(new_e)} -
                  {4'h0, rx_pop & has_err(head)};
    // overrun when a character finds the FIFO full
    if (rx_char.valid & ~rx_drop & ~rx_push) begin
      s_d.ovr = 1'b1;
    end
    // tags follow the character that becomes head
    if (rx_pop & (s_q.rx_cnt > 5'h01)) begin
      s_d.pe = s_d.pe | s_q.rx_mem[s_q.rx_rd + 4'h1].pe;
      s_d.fe = s_d.fe | s_q.rx_mem[s_q.rx_rd + 4'h1].fe;
      s_d.bi = s_d.bi | s_q.rx_mem[s_q.rx_rd + 4'h1].brk;
    end else if (rx_push & ((s_q.rx_cnt == 5'h00) |
                            (rx_pop & (s_q.rx_cnt == 5'h01)))) begin
      s_d.pe = s_d.pe | new_e.pe;
      s_d.fe = s_d.fe | new_e.fe;
      s_d.bi = s_d.bi | new_e.brk;
    end
    // arm after a break, rearm on a normal character
    if (rx_char.valid) begin
      s_d.brk_seen = rx_char.brk;
    end

    // software flow: Xoff halts, Xon resumes, or any char when Xon-any is set
    if (xoff_seen) begin
      s_d.halted = 1'b1;
    end else if (xon_seen |
                 (rx_char.valid & s_q.modem_control[ulm_pkg::MCR_XANY])) begin
      s_d.halted = 1'b0;
    end

    // holding side empties on shifter take, fills on write
    if (tx_push) begin
      s_d.tx_wr = s_q.tx_wr + 4'h1;
    end
    if (tx_pop) begin
      s_d.tx_rd = s_q.tx_rd + 4'h1;
    end
    s_d.tx_cnt = s_q.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};

    // Modem deltas; first cycle after reset only seeds the history
    s_d.prev = eff;
    if (s_q.strap_done) begin
      // CTS and DSR change in either direction
      s_d.delta[0] = s_d.delta[0] | (eff[0] ^ s_q.prev[0]);
      s_d.delta[1] = s_d.delta[1] | (eff[1] ^ s_q.prev[1]);
      // RI pin rising is the status bit falling
      s_d.delta[2] = s_d.delta[2] | (s_q.prev[2] & ~eff[2]);
      s_d.delta[3] = s_d.delta[3] | (eff[3] ^ s_q.prev[3]);
    end

    // prescaler: every cycle, or every fourth
    s_d.pre_cnt = s_q.pre_cnt + 2'h1;
    s_d.pre_tick = ~s_q.modem_control[ulm_pkg::MCR_PRESC] |
                   (s_q.pre_cnt == ulm_pkg::PRESC_LAST);

    // line-status request on flags or errored entries
    s_d.ls_irq = s_q.interrupt_enable[ulm_pkg::IER_LS] &
                 (s_d.ovr | s_d.pe | s_d.fe | s_d.bi |
                  (s_d.rx_errs != 5'h00));
    s_d.thr_irq = s_q.interrupt_enable[ulm_pkg::IER_THR] & (s_d.tx_cnt == 5'h00);
    s_d.ms_irq = s_q.interrupt_enable[ulm_pkg::IER_MS] & (s_d.delta != 4'h0);

    // loopback keeps the pin idle and feeds the receiver
    // loopback also parks the modem outputs inactive
    if (s_q.modem_control[ulm_pkg::MCR_LOOP]) begin
      s_d.serial_out = idle_lvl;
      s_d.rx_line = line_out;
      s_d.dtr_n = 1'b1;
      s_d.rts_n = 1'b1;
    end else begin
      s_d.serial_out = line_out;
      // receive path through the decoder in infrared mode
      s_d.rx_line = ir_on ? ir_rx_decoded : serial_in;
      // DTR pin; overridden when it is the flow output
      s_d.dtr_n = ~s_q.modem_control[ulm_pkg::MCR_DTR] |
                  (rx_high & s_q.modem_control[ulm_pkg::MCR_PAIR]);
      // RTS pin; overridden when it is the flow output
      s_d.rts_n = ~s_q.modem_control[ulm_pkg::MCR_RTS] |
                  (rx_high & ~s_q.modem_control[ulm_pkg::MCR_PAIR]);
    end
    // optional inversion ahead of the decoder
    s_d.ir_dec_in = serial_in ^ s_q.feat[ulm_pkg::FEAT_IR_INV];
  end

  // State register; strap bit is loaded by the first clocked cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (~presetn) begin
      s_q <= '0;
      s_q.line_control <= ulm_pkg::LCR_RST;
      // user output two and the other controls start at zero
      s_q.modem_control <= ulm_pkg::MCR_RST;
      s_q.interrupt_enable <= ulm_pkg::IER_RST;
      s_q.feat <= ulm_pkg::FEAT_RST;
      s_q.div <= ulm_pkg::DIV_RST;
      s_q.serial_out <= 1'b1;
      s_q.rx_line <= 1'b1;
      s_q.dtr_n <= 1'b1;
      s_q.rts_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign prdata = s_q.prdata;
  assign tx_data = s_q.tx_mem[s_q.tx_rd];
  assign serial_out = s_q.serial_out;
  assign rx_line = s_q.rx_line;
  assign ir_decoder_in = s_q.ir_dec_in;
  assign dtr_n = s_q.dtr_n;
  assign rts_n = s_q.rts_n;
  assign divisor = s_q.div;
  assign prescale_tick = s_q.pre_tick;
  assign ls_irq = s_q.ls_irq;
  assign thr_irq = s_q.thr_irq;
  assign ms_irq = s_q.ms_irq;

endmodule : ulm_line_modem_ctrl

// ---- inc/ulm_pkg.sv ----
// Purpose: Shared constants and carriers for the line/modem control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses; register data sits in bits 7:0
package ulm_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00; // holding regs, or divisor low
  localparam logic [7:0] OFF_IER = 8'h04;  // interrupt_enable, or divisor_high
  localparam logic [7:0] OFF_LCR = 8'h0C;
  localparam logic [7:0] OFF_MCR = 8'h10;
  localparam logic [7:0] OFF_LSR = 8'h14;
  localparam logic [7:0] OFF_MSR = 8'h18;
  localparam logic [7:0] OFF_FEAT = 8'h1C; // feature configuration

  // line_control fields
  localparam int LCR_BREAK = 6;
  localparam int LCR_DLAB = 7;
  // modem_control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_PAIR = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_XANY = 5;
  localparam int MCR_IR = 6;
  localparam int MCR_PRESC = 7;
  // interrupt_enable fields
  localparam int IER_THR = 1;
  localparam int IER_LS = 2;
  localparam int IER_MS = 3;
  // feature configuration fields
  localparam int FEAT_FIFO_EN = 0;
  localparam int FEAT_IR_INV = 4;
  localparam int FEAT_AUTOFLOW = 6;

  // Reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] FEAT_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;

  // FIFO geometry and flow threshold
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_CAP = 5'h10;
  localparam logic [4:0] FLOW_LVL = 5'h0E;
  // Prescaler divide-by-four wraps at this count
  localparam logic [1:0] PRESC_LAST = 2'h3;

  // Received character as delivered by the receive shifter
  typedef struct packed {
    logic valid;
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulm_rx_char_s;

  // Stored receive entry: tags plus data
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulm_entry_s;

  // Modem input pins, all active low
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ulm_modem_in_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] interrupt_enable;
    logic [7:0] feat;
    logic [15:0] div;
    ulm_entry_s [FIFO_DEPTH-1:0] rx_mem;
    logic [3:0] rx_rd;
    logic [3:0] rx_wr;
    logic [4:0] rx_cnt;
    logic [4:0] rx_errs;
    logic [FIFO_DEPTH-1:0][7:0] tx_mem;
    logic [3:0] tx_rd;
    logic [3:0] tx_wr;
    logic [4:0] tx_cnt;
    logic ovr;
    logic pe;
    logic fe;
    logic bi;
    logic brk_seen;
    logic halted;
    logic [3:0] delta;
    logic [3:0] prev;
    logic strap_done;
    logic [1:0] pre_cnt;
    logic pre_tick;
    logic [31:0] prdata;
    logic ls_irq;
    logic thr_irq;
    logic ms_irq;
    logic serial_out;
    logic rx_line;
    logic ir_dec_in;
    logic dtr_n;
    logic rts_n;
  } ulm_state_s;

endpackage : ulm_pkg

// ---- tb/ulm_line_modem_ctrl_properties.sv ----
// Purpose: Port-level checks for the line/modem control block
// Assumes: Shadow copies follow completed APB writes only
// Notes: Strap reloads of the infrared bit are not shadowed
`timescale 1ns/1ps

module ulm_line_modem_ctrl_properties (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and modem side
  input wire ulm_pkg::ulm_rx_char_s rx_char,
  input wire ulm_pkg::ulm_modem_in_s modem_in,
  input wire logic serial_out,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic prescale_tick,
  input wire logic ls_irq,
  input wire logic ms_irq
);
  logic [7:0] lcr_q, mcr_q, ier_q;
  logic af_q, wr_c, hit;
  logic [1:0] up_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decode of completed writes and of mapped offsets
  assign wr_c = psel && penable && pwrite && pready;
  assign hit = paddr inside {ulm_pkg::OFF_DATA, ulm_pkg::OFF_IER,
    ulm_pkg::OFF_LCR, ulm_pkg::OFF_MCR, ulm_pkg::OFF_LSR,
    ulm_pkg::OFF_MSR, ulm_pkg::OFF_FEAT};
  // Shadows; up_q hides the history seeding just after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_q <= 8'h00;
      mcr_q <= 8'h00;
      ier_q <= 8'h00;
      af_q <= 1'b0;
      up_q <= 2'h0;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      if (wr_c && paddr == ulm_pkg::OFF_LCR) lcr_q <= pwdata[7:0];
      if (wr_c && paddr == ulm_pkg::OFF_MCR) mcr_q <= pwdata[7:0];
      if (wr_c && paddr == ulm_pkg::OFF_IER && !lcr_q[7])
        ier_q <= pwdata[7:0];
      if (wr_c && paddr == ulm_pkg::OFF_FEAT) af_q <= pwdata[6];
    end
  end
  sequence quiet3;
    !prescale_tick [*3];
  endsequence
  a_break_low: assert property (
    lcr_q[6] && !mcr_q[4] |=> !serial_out) else $error("break not low");
  a_dtr_follows: assert property (
    !mcr_q[4] && !af_q |=> dtr_n == !$past(mcr_q[0]))
    else $error("dtr pin wrong");
  a_rts_follows: assert property (
    !mcr_q[4] && !af_q |=> rts_n == !$past(mcr_q[1]))
    else $error("rts pin wrong");
  a_loop_idle: assert property (
    mcr_q[4] |=> dtr_n && rts_n) else $error("pins active in loop");
  a_presc_one: assert property (
    up_q == 2'h3 && !mcr_q[7] && !$past(mcr_q[7]) |-> prescale_tick)
    else $error("tick missing");
  a_presc_four: assert property (
    mcr_q[7] && $past(mcr_q[7]) && prescale_tick |=> quiet3 ##1
    prescale_tick) else $error("tick not one in four");
  a_modem_irq: assert property (
    up_q == 2'h3 && ier_q[3] && !mcr_q[4] && ($changed(modem_in.cts_n)
    || $changed(modem_in.cd_n) || $rose(modem_in.ri_n)) |-> ##[1:3]
    ms_irq) else $error("modem irq missing");
  a_line_irq: assert property (
    ier_q[2] && rx_char.valid && (rx_char.pe || rx_char.fe ||
    rx_char.brk) |-> ##[1:2] ls_irq) else $error("line irq missing");
  a_decode_err: assert property (
    psel && penable |-> pslverr == !hit) else $error("decode error");
endmodule : ulm_line_modem_ctrl_properties

bind ulm_line_modem_ctrl ulm_line_modem_ctrl_properties u_props (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .rx_char, .modem_in, .serial_out, .dtr_n, .rts_n,
  .prescale_tick, .ls_irq, .ms_irq);

// ---- tb/ulm_modem_model.sv ----
// Purpose: Remote modem on the channel's handshake pins
// Assumes: Answers DTR with DSR and RTS with CTS
// Notes: A slow modem answers four clocks late
`timescale 1ns/1ps

module ulm_modem_model (
  // Clock
  input wire logic clk,
  // Local handshake outputs
  input wire logic dtr_n,
  input wire logic rts_n,
  // Bench commands
  input wire logic slow,
  input wire logic ring,
  input wire logic carrier,
  // Pins back to the channel
  output ulm_pkg::ulm_modem_in_s pins,
  output logic line
);
  logic [3:0] dh, rh;
  // Answer history; a slow modem uses the oldest entry
  always_ff @(posedge clk) begin
    dh <= {dh[2:0], dtr_n};
    rh <= {rh[2:0], rts_n};
  end
  // Line idles at mark, since this side sends no frames
  assign line = 1'b1;
  assign pins = {!carrier, !ring, slow ? dh[3] : dh[0],
    slow ? rh[3] : rh[0]};
endmodule : ulm_modem_model

// ---- tb/ulm_line_modem_ctrl_bench.sv ----
// Purpose: Self-checking bench for the line/modem control block
// Assumes: APB master here, modem model on the pins
// Notes: Every scenario task drives and judges, relying on state left by the tasks before it
`timescale 1ns/1ps

module ulm_line_modem_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic soft_reset, infrared_strap, xoff_seen, xon_seen, rx_line;
  logic tx_shift_bit, tx_shift_busy, tx_take, tx_valid, serial_in;
  logic ir_tx_encoded, ir_rx_decoded, ir_decoder_in, serial_out;
  logic dtr_n, rts_n, prescale_tick, ls_irq, thr_irq, ms_irq;
  logic slow, ring, carrier;
  logic [7:0] paddr, tx_data, r;
  logic [15:0] divisor;
  logic [31:0] pwdata, prdata;
  ulm_pkg::ulm_rx_char_s rx_char;
  ulm_pkg::ulm_modem_in_s modem_in;
  int n_errors, samples_checked;

  ulm_line_modem_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .soft_reset,
    .infrared_strap, .rx_char, .xoff_seen, .xon_seen, .rx_line,
    .tx_shift_bit, .tx_shift_busy, .tx_take, .tx_data, .tx_valid,
    .ir_tx_encoded, .ir_rx_decoded, .ir_decoder_in, .serial_in,
    .serial_out, .modem_in, .dtr_n, .rts_n, .divisor, .prescale_tick,
    .ls_irq, .thr_irq, .ms_irq);
  ulm_modem_model peer (.clk(pclk), .dtr_n, .rts_n, .slow, .ring,
    .carrier, .pins(modem_in), .line(serial_in));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // One APB transfer; the wait on pready is cut only by the watchdog
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), r, e);
  endtask : rc

  task automatic rx(input logic [2:0] t, input logic [7:0] d);
    @(posedge pclk);
    rx_char <= {1'b1, t, d};
    @(posedge pclk);
    rx_char <= '0;
  endtask : rx

  task automatic t_reset();
    rc(ulm_pkg::OFF_MCR, 8'h40);
    rc(ulm_pkg::OFF_LSR, 8'h60);
    rc(ulm_pkg::OFF_MSR, 8'h00);
    rc(8'h08, 8'h00);
    wr(ulm_pkg::OFF_MCR, 8'h00);
    soft_reset <= 1'b1;
    idle(1);
    soft_reset <= 1'b0;
    rc(ulm_pkg::OFF_MCR, 8'h40);
    wr(ulm_pkg::OFF_MCR, 8'h00);
  endtask : t_reset

  task automatic t_modem();
    wr(ulm_pkg::OFF_IER, 8'h0C);
    wr(ulm_pkg::OFF_MCR, 8'h03);
    idle(8);
    chk("dtr_n", dtr_n, 1'b0);
    chk("rts_n", rts_n, 1'b0);
    rc(ulm_pkg::OFF_MSR, 8'h33);
    rc(ulm_pkg::OFF_MSR, 8'h30);
    ring <= 1'b1;
    idle(3);
    rc(ulm_pkg::OFF_MSR, 8'h70);
    ring <= 1'b0;
    idle(3);
    rc(ulm_pkg::OFF_MSR, 8'h34);
    carrier <= 1'b1;
    idle(3);
    rc(ulm_pkg::OFF_MSR, 8'hB8);
    carrier <= 1'b0;
    wr(ulm_pkg::OFF_MCR, 8'h00);
    idle(8);
    rc(ulm_pkg::OFF_MSR, 8'h0B);
    slow <= 1'b0;
  endtask : t_modem

  task automatic t_div();
    wr(ulm_pkg::OFF_LCR, 8'h80);
    wr(ulm_pkg::OFF_DATA, 8'h34);
    wr(ulm_pkg::OFF_IER, 8'h12);
    idle(2);
    chk("divisor", divisor, 16'h1234);
    rc(ulm_pkg::OFF_IER, 8'h12);
    wr(ulm_pkg::OFF_LCR, 8'h00);
    rc(ulm_pkg::OFF_IER, 8'h0C);
  endtask : t_div

  task automatic t_loop();
    tx_shift_bit <= 1'b0;
    wr(ulm_pkg::OFF_MCR, 8'h1D);
    idle(3);
    chk("serial_out", serial_out, 1'b1);
    chk("rx_line", rx_line, 1'b0);
    apb(1'b0, ulm_pkg::OFF_MSR, 8'h00);
    chk("msr upper", r & 8'hF0, 8'hE0);
    wr(ulm_pkg::OFF_MCR, 8'h00);
    idle(3);
    chk("serial_out", serial_out, 1'b0);
    chk("rx_line", rx_line, 1'b1);
    tx_shift_bit <= 1'b1;
  endtask : t_loop

  task automatic t_break();
    wr(ulm_pkg::OFF_LCR, 8'h40);
    idle(2);
    chk("serial_out", serial_out, 1'b0);
    wr(ulm_pkg::OFF_LCR, 8'h00);
    idle(2);
    chk("serial_out", serial_out, 1'b1);
    wr(ulm_pkg::OFF_MCR, 8'h40);
    idle(2);
    chk("serial_out", serial_out, 1'b0);
    chk("rx_line", rx_line, 1'b0);
    chk("ir_decoder_in", ir_decoder_in, 1'b1);
    ir_tx_encoded <= 1'b1;
    idle(3);
    chk("serial_out", serial_out, 1'b1);
    wr(ulm_pkg::OFF_MCR, 8'h00);
  endtask : t_break

  task automatic t_rx();
    rx(3'b001, 8'h5A);
    rx(3'b000, 8'hC3);
    idle(1);
    rc(ulm_pkg::OFF_LSR, 8'hE7);
    rc(ulm_pkg::OFF_LSR, 8'hE1);
    rc(ulm_pkg::OFF_DATA, 8'h5A);
    rc(ulm_pkg::OFF_LSR, 8'h60);
    wr(ulm_pkg::OFF_FEAT, 8'h01);
    rx(3'b010, 8'h11);
    idle(1);
    rc(ulm_pkg::OFF_LSR, 8'hE9);
    rc(ulm_pkg::OFF_DATA, 8'h11);
    rx(3'b100, 8'h00);
    rx(3'b100, 8'h00);
    idle(1);
    rc(ulm_pkg::OFF_LSR, 8'hF1);
    rc(ulm_pkg::OFF_DATA, 8'h00);
    rc(ulm_pkg::OFF_LSR, 8'h60);
  endtask : t_rx

  task automatic t_tx();
    wr(ulm_pkg::OFF_DATA, 8'hA5);
    idle(1);
    chk("tx_data", tx_data, 8'hA5);
    rc(ulm_pkg::OFF_LSR, 8'h00);
    xoff_seen <= 1'b1;
    idle(1);
    xoff_seen <= 1'b0;
    idle(2);
    chk("tx_valid", tx_valid, 1'b0);
    wr(ulm_pkg::OFF_MCR, 8'h20);
    rx(3'b000, 8'h33);
    idle(2);
    chk("tx_valid", tx_valid, 1'b1);
    rc(ulm_pkg::OFF_DATA, 8'h33);
    tx_take <= 1'b1;
    tx_shift_busy <= 1'b1;
    idle(1);
    tx_take <= 1'b0;
    rc(ulm_pkg::OFF_LSR, 8'h20);
    tx_shift_busy <= 1'b0;
    rc(ulm_pkg::OFF_LSR, 8'h60);
    // Holding-empty request, then auto flow on the RTS/CTS pair
    wr(ulm_pkg::OFF_IER, 8'h0E);
    idle(2);
    chk("thr_irq", thr_irq, 1'b1);
    wr(ulm_pkg::OFF_FEAT, 8'h41);
    wr(ulm_pkg::OFF_DATA, 8'h5C);
    idle(2);
    chk("thr_irq", thr_irq, 1'b0);
    chk("tx_valid", tx_valid, 1'b0);
    wr(ulm_pkg::OFF_MCR, 8'h02);
    idle(3);
    chk("tx_valid", tx_valid, 1'b1);
  endtask : t_tx

  task automatic t_presc();
    logic [15:0] n;
    wr(ulm_pkg::OFF_MCR, 8'h80);
    idle(4);
    n = 16'h0000;
    repeat (16) begin
      @(posedge pclk);
      n += prescale_tick;
    end
    chk("ticks", n, 16'h0004);
  endtask : t_presc

  // Main sequence; strap high so the reset value of the IR bit shows
  initial begin
    {presetn, psel, penable, pwrite, soft_reset, xoff_seen} = '0;
    {xon_seen, tx_take, tx_shift_busy, ir_tx_encoded} = '0;
    {ir_rx_decoded, ring, carrier} = '0;
    {tx_shift_bit, infrared_strap, slow} = 3'h7;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rx_char = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    t_reset();
    t_modem();
    t_div();
    t_loop();
    t_break();
    t_rx();
    t_tx();
    t_presc();
    test_done();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done();
  end
endmodule : ulm_line_modem_ctrl_bench
